// ==== core/isdn_host_command_interpreter.sv ====
// host command interpreter: APB command mailbox, decode, codec pass-through, indications
// Notes on behaviour
// - every primitive either way is ten bytes; unused trailing bytes are ignored
// - protocol selection must come first; all other commands ignored until then
// - selection is 60 21 00 type, type one of 01 02 04 08 10
// - protocol is accepted once; later selections leave it unchanged until full reset
// - every selection command returns a status indication with the current protocol
// - status poll 60 22 returns status and counts as keep-alive
// - keep-alive watchdog is enabled out of reset
// - no poll within 60 s drops all lines until full reset
// - keep-alive control enable byte 00 turns watchdog off, 01 on
// - local number digit command stores a digit at index up to 20
// - incoming calls accepted only if the called number matches a local number
// - instance byte 00 selects instance 0, 01 selects instance 1
// - after reset both instances listen to voice and data calls
// - answer command 60 28 accepts the pending incoming call on that instance
// - codec commands 71 72 73 75 79 carry 1 2 3 5 9 payload bytes
// - codec payload goes unchanged over monitor channel one to address A1
// - codec is programmed only on host command, never by the device itself
// - command 80 hi lo value writes one line-transceiver register
// - connect acknowledgement yields indication 60 10 instance
`include "isdn_cfg.svh"
module isdn_host_command_interpreter import isdn_pkg::*; #(
	parameter logic [32:0] WD_CYCLES = `WD_CYCLES
) (
	input wire logic clk, // 100 MHz system clock
	input wire logic nrst, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic conn_ack, // connect ack received, pulse
	input wire logic conn_inst, // instance of that ack
	input wire logic call_valid, // called digit of an incoming call
	input wire logic call_inst, // instance offered the call
	input wire logic call_voice, // 1 voice call, 0 data call
	input wire logic [7:0] call_digit, // called digit, 8'h00 terminator
	input wire logic call_last, // terminator digit
	output logic answer_stb, // accept pending call, pulse
	output logic answer_inst, // instance accepted
	output logic xcvr_wr, // transceiver register write, pulse
	output xcvr_write_s xcvr, // address and value of that write
	output logic mon_valid, // monitor channel byte present
	output mon_byte_s mon, // monitor channel address, data, last
	input wire logic mon_ready, // monitor channel takes the byte
	output logic lines_down // all lines dropped, needs reset
);
	////////////////////////////////////////////////////////////////
	function automatic logic [3:0] codec_len(input logic [7:0] h);
		case (h)
			8'h71: codec_len = 4'd1;
			8'h72: codec_len = 4'd2;
			8'h73: codec_len = 4'd3;
			8'h75: codec_len = 4'd5;
			8'h79: codec_len = 4'd9;
			default: codec_len = 4'd0;
		endcase
	endfunction

	function automatic logic type_ok(input logic [7:0] t);
		type_ok = (t[7:5] == 3'd0) && (t[4:0] != 5'd0) && ((t[4:0] & (t[4:0] - 5'd1)) == 5'd0);
	endfunction

	////////////////////////////////////////////////////////////////
	// apb slave: one wait state so read data leaves a flip-flop
	logic apb_wr;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	prim_t cmd;
	prim_t ind;
	logic [31:0] stat;
	logic proto_sel;
	logic [7:0] proto;
	logic wd_en;
	logic ind_valid;
	logic ind_over;
	logic [1:0] ring;
	codec_state_e cstate;

	assign apb_wr = psel && penable && pready && pwrite;

	always_comb begin
		stat = '0;
		stat[`ST_SEL] = proto_sel;
		stat[`ST_WDEN] = wd_en;
		stat[`ST_DOWN] = lines_down;
		stat[`ST_INDV] = ind_valid;
		stat[`ST_BUSY] = (cstate == CS_SEND);
		stat[`ST_OVER] = ind_over;
		stat[`ST_RING +: 2] = ring;
		stat[`ST_PROTO +: 8] = proto;
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = '0;
		if (next_pready) begin
			case (paddr)
				`REG_CMD0: next_prdata = cmd[3:0];
				`REG_CMD1: next_prdata = cmd[7:4];
				`REG_CMD2: next_prdata = {16'h0000, cmd[9:8]};
				`REG_CTRL: next_prdata = '0;
				`REG_STAT: next_prdata = stat;
				`REG_IND0: next_prdata = ind[3:0];
				`REG_IND1: next_prdata = ind[7:4];
				`REG_IND2: next_prdata = {16'h0000, ind[9:8]};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	////////////////////////////////////////////////////////////////
	// command decode, local numbers, indications
	logic [7:0] local_subscriber_number [2][21];
	logic [7:0] stored_digit;
	logic [4:0] m_idx;
	logic m_done;
	logic m_match;
	logic kick;
	logic go;
	logic ack;
	logic status_req;
	logic codec_start;
	logic dig_wr;
	logic [1:0] listen_wr;
	logic [1:0] answer_req;
	logic [1:0] conn_hold;
	prim_t next_cmd;
	prim_t next_ind;
	logic next_proto_sel;
	logic [7:0] next_proto;
	logic next_wd_en;
	logic next_ind_valid;
	logic next_ind_over;
	logic [1:0] next_conn_hold;
	logic next_answer_stb;
	logic next_answer_inst;
	logic next_xcvr_wr;
	xcvr_write_s next_xcvr;
	logic inst_ok;
	logic inst;

	always_comb begin
		next_cmd = cmd;
		go = 1'b0;
		ack = 1'b0;
		if (apb_wr) begin
			case (paddr)
				`REG_CMD0: next_cmd[3:0] = pwdata;
				`REG_CMD1: next_cmd[7:4] = pwdata;
				`REG_CMD2: next_cmd[9:8] = pwdata[15:0];
				`REG_CTRL: begin
					go = pwdata[`CTRL_GO];
					ack = pwdata[`CTRL_ACK];
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		inst_ok = cmd[2] <= `INST_LAST;
		inst = cmd[2][0];
		next_proto_sel = proto_sel;
		next_proto = proto;
		next_wd_en = wd_en;
		status_req = 1'b0;
		kick = 1'b0;
		codec_start = 1'b0;
		dig_wr = 1'b0;
		listen_wr = 2'b00;
		answer_req = 2'b00;
		next_xcvr_wr = 1'b0;
		next_xcvr = xcvr;
		// a dead link or a busy codec transfer refuses the whole command
		if (go && !lines_down && cstate == CS_IDLE) begin
			if (cmd[0] == `HDR_CALL && cmd[1] == `OP_PROTO && cmd[2] == 8'h00) begin
				status_req = 1'b1;
				if (!proto_sel && type_ok(cmd[3])) begin
					next_proto_sel = 1'b1;
					next_proto = cmd[3];
				end
			end else if (proto_sel) begin
				if (cmd[0] == `HDR_CALL) begin
					case (cmd[1])
						`OP_STATUS: begin
							status_req = 1'b1;
							kick = 1'b1;
						end
						`OP_KEEPALIVE: begin
							if (cmd[2] <= 8'h01) begin
								next_wd_en = cmd[2][0];
							end
						end
						`OP_DIGIT: dig_wr = inst_ok && cmd[4] <= {3'd0, `MAX_INDEX};
						`OP_LISTEN: begin
							if (inst_ok && cmd[3] <= 8'h03) begin
								listen_wr[inst] = 1'b1;
							end
						end
						`OP_ANSWER: begin
							if (inst_ok) begin
								answer_req[inst] = 1'b1;
							end
						end
						default: ;
					endcase
				end else if (codec_len(cmd[0]) != 4'd0) begin
					codec_start = 1'b1;
				end else if (cmd[0] == `HDR_XCVR) begin
					next_xcvr_wr = 1'b1;
					next_xcvr.addr = {cmd[1], cmd[2]};
					next_xcvr.data = cmd[3];
				end
			end
		end
	end

	// connect indications wait in conn_hold whenever a status reply takes the slot
	always_comb begin
		next_ind = ind;
		next_ind_valid = ind_valid;
		next_ind_over = ind_over;
		next_conn_hold = conn_hold;
		if (conn_ack) begin
			next_conn_hold[conn_inst] = 1'b1;
		end
		if (ack) begin
			next_ind_valid = 1'b0;
			next_ind_over = 1'b0;
		end
		if (status_req) begin
			next_ind = '0;
			next_ind[0] = `HDR_CALL;
			next_ind[1] = `IND_STATUS;
			next_ind[2] = next_proto;
			next_ind[3] = {4'h0, lines_down, next_wd_en, ring};
			next_ind_valid = 1'b1;
			next_ind_over = ind_valid && !ack;
		end else if (conn_hold != 2'b00) begin
			next_ind = '0;
			next_ind[0] = `HDR_CALL;
			next_ind[1] = `IND_CONN;
			next_ind[2] = conn_hold[0] ? 8'h00 : 8'h01;
			next_ind_valid = 1'b1;
			next_ind_over = ind_valid && !ack;
			if (conn_hold[0]) begin
				next_conn_hold[0] = conn_ack && !conn_inst;
			end else begin
				next_conn_hold[1] = conn_ack && conn_inst;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmd <= '0;
			ind <= '0;
			proto_sel <= 1'b0;
			proto <= 8'h00;
			wd_en <= `WD_EN_RST;
			ind_valid <= 1'b0;
			ind_over <= 1'b0;
			conn_hold <= 2'b00;
			xcvr_wr <= 1'b0;
			xcvr <= '0;
		end else begin
			cmd <= next_cmd;
			ind <= next_ind;
			proto_sel <= next_proto_sel;
			proto <= next_proto;
			wd_en <= next_wd_en;
			ind_valid <= next_ind_valid;
			ind_over <= next_ind_over;
			conn_hold <= next_conn_hold;
			xcvr_wr <= next_xcvr_wr;
			xcvr <= next_xcvr;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 2; i++) begin
				for (int j = 0; j < 21; j++) begin
					local_subscriber_number[i][j] <= 8'h00;
				end
			end
		end else if (dig_wr) begin
			local_subscriber_number[inst][cmd[4][4:0]] <= cmd[3];
		end
	end

	assign stored_digit = (m_idx <= `MAX_INDEX) ? local_subscriber_number[call_inst][m_idx] : 8'h00;

	number_matcher u_match (
		.clk(clk),
		.nrst(nrst),
		.in_valid(call_valid),
		.in_digit(call_digit),
		.in_last(call_last),
		.stored_digit(stored_digit),
		.idx(m_idx),
		.done(m_done),
		.match(m_match)
	);

	keepalive_watchdog #(
		.CYCLES(WD_CYCLES)
	) u_wd (
		.clk(clk),
		.nrst(nrst),
		.enable(wd_en),
		.kick(kick),
		.expired(lines_down)
	);

	////////////////////////////////////////////////////////////////
	// per-instance listen filter and pending call
	logic call_inst_q;
	logic call_voice_q;
	logic next_answer_any;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			call_inst_q <= 1'b0;
			call_voice_q <= 1'b0;
		end else if (call_valid && call_last) begin
			call_inst_q <= call_inst;
			call_voice_q <= call_voice;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_inst
		logic [1:0] listen;
		logic [1:0] next_listen;
		logic next_ring;
		logic hears;

		always_comb begin
			next_listen = listen;
			if (listen_wr[g]) begin
				next_listen = cmd[3][1:0];
			end
			hears = call_voice_q ? listen[0] : listen[1];
			next_ring = ring[g];
			if (answer_req[g]) begin
				next_ring = 1'b0;
			end
			// a call arriving with the answer stays pending: set beats clear
			if (m_done && m_match && call_inst_q == 1'(g) && hears) begin
				next_ring = 1'b1;
			end
			if (lines_down) begin
				next_ring = 1'b0;
			end
		end

		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				listen <= `LISTEN_RST;
				ring[g] <= 1'b0;
			end else begin
				listen <= next_listen;
				ring[g] <= next_ring;
			end
		end
	end

	assign next_answer_any = (answer_req[0] && ring[0]) || (answer_req[1] && ring[1]);

	always_comb begin
		next_answer_stb = next_answer_any;
		next_answer_inst = answer_req[1];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			answer_stb <= 1'b0;
			answer_inst <= 1'b0;
		end else begin
			answer_stb <= next_answer_stb;
			answer_inst <= next_answer_inst;
		end
	end

	////////////////////////////////////////////////////////////////
	// codec pass-through on monitor channel one; payload copied so cmd may be refilled
	logic [8:0][7:0] pay;
	logic [3:0] plen;
	logic [3:0] pidx;
	logic [8:0][7:0] next_pay;
	logic [3:0] next_plen;
	logic [3:0] next_pidx;
	codec_state_e next_cstate;
	logic next_mon_valid;
	mon_byte_s next_mon;

	always_comb begin
		next_pay = pay;
		next_plen = plen;
		next_pidx = pidx;
		next_cstate = cstate;
		next_mon_valid = mon_valid;
		next_mon = mon;
		unique case (cstate)
			CS_IDLE: begin
				if (codec_start) begin
					next_pay = cmd[9:1];
					next_plen = codec_len(cmd[0]);
					next_pidx = 4'd0;
					next_mon_valid = 1'b1;
					next_mon.addr = `CODEC_ADDR;
					next_mon.data = cmd[1];
					next_mon.last = codec_len(cmd[0]) == 4'd1;
					next_cstate = CS_SEND;
				end
			end
			CS_SEND: begin
				if (mon_ready) begin
					if (mon.last) begin
						next_mon_valid = 1'b0;
						next_cstate = CS_IDLE;
					end else begin
						next_pidx = pidx + 4'd1;
						next_mon.data = pay[next_pidx];
						next_mon.last = next_pidx == plen - 4'd1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pay <= '0;
			plen <= 4'd0;
			pidx <= 4'd0;
			cstate <= CS_IDLE;
			mon_valid <= 1'b0;
			mon <= '0;
		end else begin
			pay <= next_pay;
			plen <= next_plen;
			pidx <= next_pidx;
			cstate <= next_cstate;
			mon_valid <= next_mon_valid;
			mon <= next_mon;
		end
	end
endmodule

// ==== core/isdn_cfg.svh ====
// offsets, field positions, reset values and timing counts of the command interpreter
`ifndef ISDN_CFG_SVH
`define ISDN_CFG_SVH
`define PRIM_BYTES 10
`define HDR_CALL 8'h60
`define OP_PROTO 8'h21
`define OP_STATUS 8'h22
`define OP_DIGIT 8'h23
`define OP_KEEPALIVE 8'h26
`define OP_LISTEN 8'h27
`define OP_ANSWER 8'h28
`define HDR_XCVR 8'h80
`define IND_CONN 8'h10
`define IND_STATUS 8'h20
`define CODEC_ADDR 8'hA1
`define MAX_INDEX 5'd20
`define INST_LAST 8'h01
`define LISTEN_RST 2'h3
`define WD_EN_RST 1'b1
`define WD_TIME_S 60
`define CLK_HZ 100000000
`define WD_CYCLES (33'(`WD_TIME_S) * 33'(`CLK_HZ))
`define REG_CMD0 8'h00
`define REG_CMD1 8'h04
`define REG_CMD2 8'h08
`define REG_CTRL 8'h0C
`define REG_STAT 8'h10
`define REG_IND0 8'h14
`define REG_IND1 8'h18
`define REG_IND2 8'h1C
`define CTRL_GO 0
`define CTRL_ACK 1
`define ST_SEL 0
`define ST_WDEN 1
`define ST_DOWN 2
`define ST_INDV 3
`define ST_BUSY 4
`define ST_OVER 5
`define ST_RING 6
`define ST_PROTO 8
`endif

// ==== core/isdn_pkg.sv ====
// types shared by the command interpreter files
package isdn_pkg;
	typedef logic [9:0][7:0] prim_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic last;
	} mon_byte_s;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
	} xcvr_write_s;
	typedef enum logic [1:0] {
		CS_IDLE = 2'b01,
		CS_SEND = 2'b10
	} codec_state_e;
endpackage

// ==== core/keepalive_watchdog.sv ====
// keep-alive timer: expires when no kick arrives within the window while enabled
module keepalive_watchdog #(
	parameter logic [32:0] CYCLES = 33'd1000
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic enable, // timer armed
	input wire logic kick, // status poll seen
	output logic expired // sticky until reset
);
	logic [32:0] count;
	logic [32:0] next_count;
	logic next_expired;

	always_comb begin
		next_count = count;
		next_expired = expired;
		if (!enable || kick) begin
			next_count = '0;
		end else if (!expired) begin
			if (count >= CYCLES - 33'd1) begin
				next_expired = 1'b1;
			end else begin
				next_count = count + 33'd1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end
endmodule

// ==== core/number_matcher.sv ====
// compares a called number, digit by digit, with a stored local number
`include "isdn_cfg.svh"
module number_matcher (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic in_valid, // one called digit present
	input wire logic [7:0] in_digit, // called digit, 8'h00 ends the number
	input wire logic in_last, // this digit is the terminator
	input wire logic [7:0] stored_digit, // stored digit at idx
	output logic [4:0] idx, // digit position being compared
	output logic done, // one-cycle pulse after the terminator
	output logic match // number equal and not empty, valid with done
);
	logic ok;
	logic next_ok;
	logic [4:0] next_idx;
	logic next_done;
	logic next_match;
	logic eq;

	always_comb begin
		eq = (in_digit == stored_digit) && (idx <= `MAX_INDEX);
		next_ok = ok;
		next_idx = idx;
		next_done = 1'b0;
		next_match = match;
		if (in_valid) begin
			if (in_last) begin
				next_done = 1'b1;
				next_match = ok && eq && (in_digit == 8'h00) && (idx != 5'd0);
				next_ok = 1'b1;
				next_idx = 5'd0;
			end else begin
				next_ok = ok && eq;
				if (idx <= `MAX_INDEX) begin
					next_idx = idx + 5'd1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ok <= 1'b1;
			idx <= 5'd0;
			done <= 1'b0;
			match <= 1'b0;
		end else begin
			ok <= next_ok;
			idx <= next_idx;
			done <= next_done;
			match <= next_match;
		end
	end
endmodule

// ==== tb/codec_sink.sv ====
// monitor channel codec stand-in that accepts bytes with random stalls
module codec_sink import isdn_pkg::*; (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic mon_valid, // byte offered
	input wire mon_byte_s mon, // address, data, last
	output logic mon_ready // byte taken at this edge
);
	timeunit 1ns;
	timeprecision 1ps;
	mon_byte_s got[$];
	// ready toggles at random so that both prompt and slow acceptance are exercised
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mon_ready <= 1'b0;
		end else begin
			if (mon_valid === 1'b1 && mon_ready) begin
				got.push_back(mon);
			end
			mon_ready <= ($urandom_range(0, 3) != 0);
		end
	end
endmodule

// ==== tb/isdn_cmd_asserts.sv ====
// concurrent checks on the command interpreter ports
`include "isdn_cfg.svh"
module isdn_cmd_asserts import isdn_pkg::*; (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [7:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic pready, // apb ready
	input wire logic xcvr_wr, // transceiver write pulse
	input wire logic answer_stb, // accept pulse
	input wire logic mon_valid, // monitor byte present
	input wire mon_byte_s mon, // monitor byte
	input wire logic mon_ready, // monitor byte taken
	input wire logic lines_down // lines dropped
);
	logic go_q;
	logic next_go_q;
	always_comb begin
		next_go_q = psel && penable && pready && pwrite && paddr == `REG_CTRL && pwdata[`CTRL_GO];
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			go_q <= 1'b0;
		end else begin
			go_q <= next_go_q;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence offer_held;
		mon_valid && !mon_ready;
	endsequence
	sequence last_taken;
		mon_valid && mon_ready && mon.last;
	endsequence
	chk_codec_cause: assert property ($rose(mon_valid) |-> go_q)
		else $error("codec traffic without a host command");
	chk_mon_addr: assert property (mon_valid |-> mon.addr == `CODEC_ADDR)
		else $error("monitor byte to wrong address");
	chk_mon_hold: assert property (offer_held |=> mon_valid && $stable(mon))
		else $error("monitor byte changed before acceptance");
	chk_mon_end: assert property (last_taken |=> !mon_valid)
		else $error("monitor traffic beyond last byte");
	chk_xcvr_cause: assert property (xcvr_wr |-> go_q && !$past(lines_down))
		else $error("transceiver write without command");
	chk_answer_once: assert property (answer_stb |-> go_q ##1 !answer_stb)
		else $error("accept pulse without command or too long");
	chk_down_sticky: assert property (lines_down |=> lines_down)
		else $error("lines came back without reset");
	chk_down_quiet: assert property ($past(lines_down) |-> !xcvr_wr && !answer_stb && !$rose(mon_valid))
		else $error("action while lines down");
endmodule
bind isdn_host_command_interpreter isdn_cmd_asserts u_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .xcvr_wr(xcvr_wr), .answer_stb(answer_stb),
	.mon_valid(mon_valid), .mon(mon), .mon_ready(mon_ready), .lines_down(lines_down));

// ==== tb/isdn_host_command_interpreter_tb.sv ====
// self-checking bench for the host command interpreter
`include "isdn_cfg.svh"
module isdn_host_command_interpreter_tb import isdn_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WD = 200;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic conn_ack = 1'b0, conn_inst = 1'b0, call_valid = 1'b0, call_inst = 1'b0, call_voice = 1'b0, call_last = 1'b0;
	logic [7:0] paddr = 8'h00, call_digit = 8'h00, ty, d0, d1;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, answer_stb, answer_inst, xcvr_wr, mon_valid, mon_ready, lines_down, err, ans_i;
	xcvr_write_s xcvr, xw;
	mon_byte_s mon;
	prim_t p;
	int miscompares = 0, compares = 0, ans_cnt = 0, xw_cnt = 0;
	logic [7:0] codes [5] = '{8'h71, 8'h72, 8'h73, 8'h75, 8'h79};
	int lens [5] = '{1, 2, 3, 5, 9};
	isdn_host_command_interpreter #(.WD_CYCLES(33'(WD))) DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.conn_ack(conn_ack), .conn_inst(conn_inst), .call_valid(call_valid), .call_inst(call_inst),
		.call_voice(call_voice), .call_digit(call_digit), .call_last(call_last), .answer_stb(answer_stb),
		.answer_inst(answer_inst), .xcvr_wr(xcvr_wr), .xcvr(xcvr), .mon_valid(mon_valid), .mon(mon),
		.mon_ready(mon_ready), .lines_down(lines_down));
	codec_sink pm (.clk(clk), .nrst(nrst), .mon_valid(mon_valid), .mon(mon), .mon_ready(mon_ready));
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (xcvr_wr === 1'b1) begin
			xw = xcvr;
			xw_cnt++;
		end
		if (answer_stb === 1'b1) begin
			ans_cnt++;
			ans_i = answer_inst;
		end
	end
	////////////////////////////////////////////////////////////////
	task end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// request held until pready is sampled high; one idle cycle after keeps psel single-assigned
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			chk(1'b0, 1'b1, "apb timeout");
			end_sim();
		end
	endtask
	task cmd(input logic [31:0] w0, input logic [31:0] w1 = 32'h0, input logic [31:0] w2 = 32'h0);
		apb(1'b1, `REG_CMD0, w0);
		apb(1'b1, `REG_CMD1, w1);
		apb(1'b1, `REG_CMD2, w2);
		apb(1'b1, `REG_CTRL, 32'h1);
		@(posedge clk);
	endtask
	task ring(input logic inst, input logic voice, input logic [7:0] a, input logic [7:0] b);
		logic [7:0] dg [3];
		dg = '{a, b, 8'h00};
		call_inst <= inst;
		call_voice <= voice;
		for (int i = 0; i < 3; i++) begin
			call_valid <= 1'b1;
			call_digit <= dg[i];
			call_last <= (i == 2);
			@(posedge clk);
		end
		call_valid <= 1'b0;
		call_last <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, `REG_STAT, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int n;
		void'($urandom(32'h9612));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q[15:0], 16'h0002, "stat after reset");
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1, "unmapped error");
		chk(q, 32'h0, "unmapped data");
		cmd(32'h0000_2260);
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q[3], 1'b0, "poll before select");
		$display("test reset done");
		ty = 8'h01 << $urandom_range(0, 4);
		cmd({ty, 24'h002160});
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q[15:0], {ty, 8'h0B}, "stat after select");
		apb(1'b0, `REG_IND0, 32'h0);
		chk(q, {8'h04, ty, 16'h2060}, "status indication");
		apb(1'b1, `REG_CTRL, 32'h2);
		cmd({(ty == 8'h01) ? 8'h02 : 8'h01, 24'h002160});
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q[15:0], {ty, 8'h0B}, "second select");
		apb(1'b1, `REG_CTRL, 32'h2);
		cmd(32'h0000_2660);
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q[1], 1'b0, "keepalive off");
		d0 = 8'h30 + 8'($urandom_range(0, 9));
		d1 = 8'h30 + 8'($urandom_range(0, 9));
		cmd({d0, 24'h002360}, 32'h0);
		cmd({d1, 24'h002360}, 32'h1);
		cmd(32'h0000_2360, 32'h2);
		apb(1'b1, `REG_CTRL, 32'h2);
		cmd(32'h0000_2261);
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q[3], 1'b0, "bad header");
		cmd(32'h0000_2260);
		apb(1'b0, `REG_STAT, 32'h0);
		chk(q[3], 1'b1, "poll answered");
		apb(1'b1, `REG_CTRL, 32'h2);
		$display("test select done");
		for (int c = 0; c < 5; c++) begin
			p = {16'($urandom()), $urandom(), $urandom()};
			p[0] = codes[c];
			pm.got.delete();
			cmd(p[3:0], p[7:4], 32'(p[9:8]));
			n = 0;
			while (pm.got.size() < lens[c] && n < 300) begin
				@(posedge clk);
				n++;
			end
			if (n >= 300) begin
				chk(1'b0, 1'b1, "codec timeout");
				end_sim();
			end
			repeat (2) @(posedge clk);
			chk(pm.got.size(), lens[c], "codec count");
			foreach (pm.got[i]) chk({pm.got[i].addr, pm.got[i].data, 7'h0, pm.got[i].last},
				{`CODEC_ADDR, p[i + 1], 7'h0, i == lens[c] - 1}, "codec byte");
		end
		p = {16'h0, $urandom(), $urandom()};
		p[0] = `HDR_XCVR;
		cmd(p[3:0]);
		chk(xw_cnt, 1, "xcvr pulses");
		chk(xw, {p[1], p[2], p[3]}, "xcvr write");
		conn_inst <= 1'b1;
		conn_ack <= 1'b1;
		@(posedge clk);
		conn_ack <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b0, `REG_IND0, 32'h0);
		chk(q[23:0], 24'h011060, "connect indication");
		apb(1'b1, `REG_CTRL, 32'h2);
		$display("test codec done");
		ring(1'b0, 1'b1, d0, d1);
		chk(q[7:6], 2'b01, "ring on match");
		cmd(32'h0000_2860);
		chk(ans_cnt, 1, "answer count");
		chk(ans_i, 1'b0, "answer instance");
		ring(1'b0, 1'b1, d0, d1 ^ 8'h01);
		chk(q[7:6], 2'b00, "other number");
		cmd(32'h0200_2760);
		ring(1'b0, 1'b1, d0, d1);
		chk(q[7:6], 2'b00, "voice filtered");
		ring(1'b0, 1'b0, d0, d1);
		chk(q[7:6], 2'b01, "data listened");
		cmd(32'h0002_2860);
		chk(ans_cnt, 1, "bad instance answer");
		ring(1'b1, 1'b1, d0, d1);
		chk(q[7:6], 2'b01, "second instance empty");
		$display("test calls done");
		cmd(32'h0001_2660);
		repeat (150) @(posedge clk);
		cmd(32'h0000_2260);
		repeat (150) @(posedge clk);
		chk(lines_down, 1'b0, "kept alive");
		repeat (WD - 100) @(posedge clk);
		chk(lines_down, 1'b1, "expired");
		pm.got.delete();
		cmd(32'h0000_5571);
		repeat (20) @(posedge clk);
		chk(pm.got.size(), 0, "codec while down");
		$display("test watchdog done");
		end_sim();
	end
endmodule
